// ==== logic/rras_defs.svh ====
// Purpose: Offsets, field positions and reset values of the range and
//          alarm register block.
// Assumes: 32-bit AXI4-Lite data, byte addressing.
// Notes:   Definitions only.
`ifndef RRAS_DEFS_SVH
`define RRAS_DEFS_SVH

// ===========================================================
// Register byte addresses
`define RRAS_OFF_RANGE   8'h14
`define RRAS_OFF_ALARM   8'h20
`define RRAS_OFF_OUTCTL  8'h10
`define RRAS_OFF_IRQST   8'h30
`define RRAS_OFF_IRQMSK  8'h34

// ===========================================================
// Field positions
`define RRAS_RANGE_LSB   0
`define RRAS_RANGE_MSB   3
`define RRAS_REFOFF_BIT  6
`define RRAS_A_SUP_LO    15
`define RRAS_A_SUP_HI    14
`define RRAS_A_IN_LO     11
`define RRAS_A_IN_HI     10
`define RRAS_T_SUP_LO    7
`define RRAS_T_SUP_HI    6
`define RRAS_T_IN_LO     5
`define RRAS_T_IN_HI     4
`define RRAS_ANY_BIT     0
`define RRAS_FADD_RANGE  8
`define RRAS_FADD_IN_LSB 10
`define RRAS_FADD_IN_MSB 11

// ===========================================================
// Reset values and codes
`define RRAS_RANGE_RST   4'h0
`define RRAS_REFOFF_RST  1'b0
`define RRAS_OUTCTL_RST  3'h0
`define RRAS_RESP_OKAY   2'h0
`define RRAS_RESP_SLVERR 2'h2
`define RRAS_LAST_BIPOL  4'h4
`define RRAS_FIRST_UNI   4'h8
`define RRAS_LAST_UNI    4'hb

`endif

// ==== logic/rras_pkg.sv ====
// Purpose: Types shared by the range and alarm register block.
// Assumes: Constants come from rras_defs.svh.
// Notes:   Types only.
`default_nettype none

package rras_pkg;

    // Four alarm conditions, one bit each
    typedef struct packed {
        logic supply_low;
        logic supply_high;
        logic input_low;
        logic input_high;
    } rras_alarm_s;

    // Frame content controls
    typedef struct packed {
        logic       frame_add_range;
        logic [1:0] frame_add_input_alarms;
    } rras_frame_s;

    // Read channel state
    typedef enum logic [0:0] {
        RRAS_RD_IDLE = 1'b0,
        RRAS_RD_RESP = 1'b1
    } rras_rd_e;

    // Write channel state, Gray along idle-resp
    typedef enum logic [1:0] {
        RRAS_WR_IDLE = 2'b00,
        RRAS_WR_RESP = 2'b01
    } rras_wr_e;

endpackage

`default_nettype wire

// ==== logic/rras_regs.sv ====
// Purpose: Range select and alarm status registers behind AXI4-Lite.
// Assumes: Live alarm levels arrive synchronous to clk_sys, sampled on
//          each conversion_done pulse.
// Notes:   One write and one read in flight at most.
// How it works
// - Four-bit range field, bits 3-0, resets zero
// - Codes 0-4 pick bipolar scalings
// - Codes 8-b pick unipolar scalings
// - Bit 6 turns on-chip reference off
// - Reserved bits read zero, read-only
// - Alarm register ignores all writes
// - Bits 15,14 live supply low/high
// - Bits 11,10 live input low/high
// - Bits 7,6 caught supply low/high
// - Bits 5,4 caught input low/high
// - Bit 0 ORs all caught flags
// - Flags one when condition, reset zero
// - Range register at bytes 14h-17h
// - Alarm register at bytes 20h-23h
// - Range-include bit adds range to frame
// - Two-bit field picks input alarms for frame when range-include bit clear
//
// The implementer's own choice: register access over AXI4-Lite.
`include "rras_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module rras_regs
(
    input  wire logic                 clk_sys,
    input  wire logic                 reset_n,
    // AXI4-Lite slave
    input  wire logic [7:0]           s_axi_awaddr,
    input  wire logic                 s_axi_awvalid,
    output logic                      s_axi_awready,
    input  wire logic [31:0]          s_axi_wdata,
    input  wire logic [3:0]           s_axi_wstrb,
    input  wire logic                 s_axi_wvalid,
    output logic                      s_axi_wready,
    output logic [1:0]                s_axi_bresp,
    output logic                      s_axi_bvalid,
    input  wire logic                 s_axi_bready,
    input  wire logic [7:0]           s_axi_araddr,
    input  wire logic                 s_axi_arvalid,
    output logic                      s_axi_arready,
    output logic [31:0]               s_axi_rdata,
    output logic [1:0]                s_axi_rresp,
    output logic                      s_axi_rvalid,
    input  wire logic                 s_axi_rready,
    // Comparator side
    input  wire logic                 conversion_done,
    input  wire rras_pkg::rras_alarm_s alarm_cond,
    // Block controls
    output logic [3:0]                range_select,
    output logic                      onchip_reference_off,
    output rras_pkg::rras_frame_s     frame_ctl,
    output logic [3:0]                frame_extra,
    output logic                      irq
);

    // ===========================================================
    // Range code check
    function automatic logic range_ok(input logic [3:0] code);
        range_ok = (code <= `RRAS_LAST_BIPOL) ||
                   ((code >= `RRAS_FIRST_UNI) && (code <= `RRAS_LAST_UNI));
    endfunction

    // ===========================================================
    // State
    rras_pkg::rras_wr_e    wr_q;
    rras_pkg::rras_rd_e    rd_q;
    logic                  aw_got_q;
    logic                  w_got_q;
    logic [7:0]            awaddr_q;
    logic [31:0]           wdata_q;
    logic [3:0]            wstrb_q;
    logic [1:0]            bresp_q;
    logic [31:0]           rdata_q;
    logic [1:0]            rresp_q;
    logic [3:0]            range_q;
    logic                  refoff_q;
    rras_pkg::rras_frame_s outctl_q;
    rras_pkg::rras_alarm_s live_q;
    rras_pkg::rras_alarm_s caught_q;
    logic [3:0]            irq_st_q;
    logic [3:0]            irq_msk_q;

    // ===========================================================
    // Write channel decode
    wire        aw_fire  = s_axi_awvalid && s_axi_awready;
    wire        w_fire   = s_axi_wvalid && s_axi_wready;
    wire        aw_have  = aw_got_q || aw_fire;
    wire        w_have   = w_got_q || w_fire;
    wire [7:0]  wa       = aw_got_q ? awaddr_q : s_axi_awaddr;
    wire [31:0] wd       = w_got_q ? wdata_q : s_axi_wdata;
    wire [3:0]  ws       = w_got_q ? wstrb_q : s_axi_wstrb;
    wire        wr_go    = (wr_q == rras_pkg::RRAS_WR_IDLE) && aw_have &&
                           w_have;
    wire        wa_range = (wa == `RRAS_OFF_RANGE);
    wire        wa_alarm = (wa == `RRAS_OFF_ALARM);
    wire        wa_out   = (wa == `RRAS_OFF_OUTCTL);
    wire        wa_ist   = (wa == `RRAS_OFF_IRQST);
    wire        wa_imk   = (wa == `RRAS_OFF_IRQMSK);
    wire        wa_hit   = wa_range || wa_alarm || wa_out || wa_ist ||
                           wa_imk;
    wire [3:0]  new_rng  = wd[`RRAS_RANGE_MSB:`RRAS_RANGE_LSB];
    wire        wr_rng   = wr_go && wa_range && ws[0];
    wire        rng_load = wr_rng && range_ok(new_rng);
    wire        wr_out   = wr_go && wa_out && ws[1];
    wire        wr_ist   = wr_go && wa_ist && ws[0];
    wire        wr_imk   = wr_go && wa_imk && ws[0];

    // Channel readies, combinational
    assign s_axi_awready = (wr_q == rras_pkg::RRAS_WR_IDLE) && !aw_got_q;
    assign s_axi_wready  = (wr_q == rras_pkg::RRAS_WR_IDLE) && !w_got_q;
    assign s_axi_bvalid  = (wr_q == rras_pkg::RRAS_WR_RESP);
    assign s_axi_bresp   = bresp_q;

    // ===========================================================
    // Read channel decode
    wire        rd_go    = s_axi_arvalid && s_axi_arready;
    wire        ra_range = (s_axi_araddr == `RRAS_OFF_RANGE);
    wire        ra_alarm = (s_axi_araddr == `RRAS_OFF_ALARM);
    wire        ra_out   = (s_axi_araddr == `RRAS_OFF_OUTCTL);
    wire        ra_ist   = (s_axi_araddr == `RRAS_OFF_IRQST);
    wire        ra_imk   = (s_axi_araddr == `RRAS_OFF_IRQMSK);
    wire        ra_hit   = ra_range || ra_alarm || ra_out || ra_ist ||
                           ra_imk;
    wire        alarm_rd = rd_go && ra_alarm;

    // Read word images, reserved bits zero
    logic [31:0] img_range;
    logic [31:0] img_alarm;
    logic [31:0] img_out;
    always_comb
    begin
        img_range = 32'h0;
        img_range[`RRAS_RANGE_MSB:`RRAS_RANGE_LSB] = range_q;
        img_range[`RRAS_REFOFF_BIT] = refoff_q;
        img_alarm = 32'h0;
        img_alarm[`RRAS_A_SUP_LO] = live_q.supply_low;
        img_alarm[`RRAS_A_SUP_HI] = live_q.supply_high;
        img_alarm[`RRAS_A_IN_LO]  = live_q.input_low;
        img_alarm[`RRAS_A_IN_HI]  = live_q.input_high;
        img_alarm[`RRAS_T_SUP_LO] = caught_q.supply_low;
        img_alarm[`RRAS_T_SUP_HI] = caught_q.supply_high;
        img_alarm[`RRAS_T_IN_LO]  = caught_q.input_low;
        img_alarm[`RRAS_T_IN_HI]  = caught_q.input_high;
        img_alarm[`RRAS_ANY_BIT]  = |caught_q;
        img_out = 32'h0;
        img_out[`RRAS_FADD_RANGE] = outctl_q.frame_add_range;
        img_out[`RRAS_FADD_IN_MSB:`RRAS_FADD_IN_LSB] =
            outctl_q.frame_add_input_alarms;
    end

    wire [31:0] rd_word = ra_range ? img_range :
                          ra_alarm ? img_alarm :
                          ra_out   ? img_out   :
                          ra_ist   ? {28'h0, irq_st_q} :
                          ra_imk   ? {28'h0, irq_msk_q} : 32'h0;

    assign s_axi_arready = (rd_q == rras_pkg::RRAS_RD_IDLE);
    assign s_axi_rvalid  = (rd_q == rras_pkg::RRAS_RD_RESP);
    assign s_axi_rdata   = rdata_q;
    assign s_axi_rresp   = rresp_q;

    // ===========================================================
    // Alarm flags: live sampled per conversion, caught sticky
    wire                   conv     = conversion_done;
    rras_pkg::rras_alarm_s live_d;
    rras_pkg::rras_alarm_s caught_d;
    assign live_d   = conv ? alarm_cond : live_q;
    // Read clears, set wins; condition still present holds it
    assign caught_d = (alarm_rd ? live_d : caught_q) |
                      (conv ? alarm_cond : 4'h0);
    wire [3:0] new_evt = (conv ? alarm_cond : 4'h0) & ~caught_q;

    // ===========================================================
    // Write FSM
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            wr_q     <= rras_pkg::RRAS_WR_IDLE;
            aw_got_q <= 1'b0;
            w_got_q  <= 1'b0;
            awaddr_q <= 8'h0;
            wdata_q  <= 32'h0;
            wstrb_q  <= 4'h0;
            bresp_q  <= `RRAS_RESP_OKAY;
        end
        else
        begin
            case (wr_q)
                rras_pkg::RRAS_WR_IDLE:
                begin
                    if (aw_fire)
                        awaddr_q <= s_axi_awaddr;
                    if (w_fire)
                    begin
                        wdata_q <= s_axi_wdata;
                        wstrb_q <= s_axi_wstrb;
                    end
                    aw_got_q <= aw_have && !wr_go;
                    w_got_q  <= w_have && !wr_go;
                    if (wr_go)
                    begin
                        wr_q    <= rras_pkg::RRAS_WR_RESP;
                        bresp_q <= wa_hit ? `RRAS_RESP_OKAY
                                          : `RRAS_RESP_SLVERR;
                    end
                end
                rras_pkg::RRAS_WR_RESP:
                    if (s_axi_bready)
                        wr_q <= rras_pkg::RRAS_WR_IDLE;
                default:
                    wr_q <= rras_pkg::RRAS_WR_IDLE;
            endcase
        end
    end

    // ===========================================================
    // Read FSM
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            rd_q    <= rras_pkg::RRAS_RD_IDLE;
            rdata_q <= 32'h0;
            rresp_q <= `RRAS_RESP_OKAY;
        end
        else
        begin
            case (rd_q)
                rras_pkg::RRAS_RD_IDLE:
                    if (rd_go)
                    begin
                        rd_q    <= rras_pkg::RRAS_RD_RESP;
                        rdata_q <= rd_word;
                        rresp_q <= ra_hit ? `RRAS_RESP_OKAY
                                          : `RRAS_RESP_SLVERR;
                    end
                rras_pkg::RRAS_RD_RESP:
                    if (s_axi_rready)
                        rd_q <= rras_pkg::RRAS_RD_IDLE;
                default:
                    rd_q <= rras_pkg::RRAS_RD_IDLE;
            endcase
        end
    end

    // ===========================================================
    // Control registers; alarm register has no write path
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            range_q   <= `RRAS_RANGE_RST;
            refoff_q  <= `RRAS_REFOFF_RST;
            outctl_q  <= `RRAS_OUTCTL_RST;
            irq_msk_q <= 4'h0;
        end
        else
        begin
            if (rng_load)
                range_q <= new_rng;
            if (wr_rng)
                refoff_q <= wd[`RRAS_REFOFF_BIT];
            if (wr_out)
            begin
                outctl_q.frame_add_range <= wd[`RRAS_FADD_RANGE];
                outctl_q.frame_add_input_alarms <=
                    wd[`RRAS_FADD_IN_MSB:`RRAS_FADD_IN_LSB];
            end
            if (wr_imk)
                irq_msk_q <= wd[3:0];
        end
    end

    // ===========================================================
    // Alarm flags and interrupt status
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            live_q   <= 4'h0;
            caught_q <= 4'h0;
            irq_st_q <= 4'h0;
        end
        else
        begin
            live_q   <= live_d;
            caught_q <= caught_d;
            irq_st_q <= (irq_st_q & ~(wr_ist ? wd[3:0] : 4'h0)) | new_evt;
        end
    end

    // ===========================================================
    // Outputs
    assign range_select         = range_q;
    assign onchip_reference_off = refoff_q;
    assign frame_ctl            = outctl_q;
    assign irq                  = |(irq_st_q & irq_msk_q);

    // Frame extras: range nibble or selected live input alarms
    always_comb
    begin
        frame_extra = 4'h0;
        if (outctl_q.frame_add_range)
            frame_extra = range_q;
        else
        begin
            frame_extra[1] = outctl_q.frame_add_input_alarms[1] &&
                             live_q.input_low;
            frame_extra[0] = outctl_q.frame_add_input_alarms[0] &&
                             live_q.input_high;
        end
    end

    // ===========================================================
    // Assertions
    // Overall bit checked on the word the host really receives
    AST_ANY_OR: assert property (@(posedge clk_sys)
        disable iff (!reset_n)
        rd_go && ra_alarm |=>
        s_axi_rdata[`RRAS_ANY_BIT] == |s_axi_rdata[7:4])
        else $error("overall alarm bit not OR of caught flags");
    AST_RSV_RANGE: assert property (@(posedge clk_sys)
        disable iff (!reset_n)
        s_axi_rvalid && $past(ra_range && rd_go) |->
        (s_axi_rdata & 32'hffffffb0) == 32'h0)
        else $error("range reserved bits nonzero");
    AST_RSV_ALARM: assert property (@(posedge clk_sys)
        disable iff (!reset_n)
        rd_go && ra_alarm |=> (s_axi_rdata & 32'hffff330e) == 32'h0)
        else $error("alarm reserved bits nonzero");
    AST_RANGE_OK: assert property (@(posedge clk_sys)
        disable iff (!reset_n) range_ok(range_q))
        else $error("range holds a reserved code");
    AST_RANGE_WR: assert property (@(posedge clk_sys)
        disable iff (!reset_n)
        rng_load |=> range_select == $past(new_rng))
        else $error("range write not applied");
    AST_REF_WR: assert property (@(posedge clk_sys) disable iff (!reset_n)
        wr_rng |=> onchip_reference_off == $past(wd[`RRAS_REFOFF_BIT]))
        else $error("reference off not written");
    AST_CAUGHT: assert property (@(posedge clk_sys) disable iff (!reset_n)
        conv && alarm_cond.supply_low |=> caught_q.supply_low)
        else $error("caught flag not set by condition");
    AST_HOLD: assert property (@(posedge clk_sys) disable iff (!reset_n)
        caught_q.input_high && !alarm_rd |=> caught_q.input_high)
        else $error("caught flag lost without read");
    AST_LIVE: assert property (@(posedge clk_sys) disable iff (!reset_n)
        !conv |=> $stable(live_q))
        else $error("live flags changed without conversion");
    AST_BRESP: assert property (@(posedge clk_sys) disable iff (!reset_n)
        wr_go |=> s_axi_bvalid)
        else $error("write response missing");
    // A host write to the alarm word must leave every flag alone
    AST_ALARM_RO: assert property (@(posedge clk_sys)
        disable iff (!reset_n)
        wr_go && wa_alarm && !conv && !alarm_rd |=>
        $stable(caught_q) && $stable(live_q))
        else $error("alarm register changed by a write");

    COV_RANGE_UNI: cover property (@(posedge clk_sys)
        rng_load && new_rng == `RRAS_LAST_UNI);
    COV_BAD_CODE: cover property (@(posedge clk_sys)
        wr_rng && !range_ok(new_rng));
    COV_READ_CLR: cover property (@(posedge clk_sys)
        alarm_rd && |caught_q ##1 caught_q == 4'h0);
    COV_IRQ: cover property (@(posedge clk_sys) $rose(irq));
    COV_ALARM_WR: cover property (@(posedge clk_sys)
        wr_go && wa_alarm);

endmodule

`default_nettype wire

// ==== tb/range_ref_alarm_status_regs_tb.sv ====
// Purpose: Self-checking bench of the range and alarm register block.
// Assumes: Host model drives AXI4-Lite; bench drives comparator side.
// Notes:   Expected values built here, never read from the block.
`include "rras_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module range_ref_alarm_status_regs_tb;
    logic clk_sys = 1'b0, reset_n = 1'b0, conv = 1'b0;
    rras_pkg::rras_alarm_s cond = '0;
    logic [7:0]  awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [3:0]  wstrb, rsel, fx;
    logic [1:0]  bresp, rresp;
    logic awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, refoff, irq;
    rras_pkg::rras_frame_s fctl;
    int err_count = 0, cmp_count = 0, cyc = 0;
    logic [1:0] r;
    logic [3:0] exp_rng;

    // ===========================================================
    // Clock, timeout
    always #2.5 clk_sys = ~clk_sys;
    always @(posedge clk_sys)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            err_count++;
            give_verdict();
        end
    end

    rras_host u_host (.clk_sys(clk_sys), .awaddr(awaddr),
        .awvalid(awvalid), .awready(awready), .wdata(wdata),
        .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
        .bvalid(bvalid), .bready(bready), .araddr(araddr),
        .arvalid(arvalid), .arready(arready), .rdata(rdata),
        .rresp(rresp), .rvalid(rvalid), .rready(rready));

    rras_regs u_dut (.clk_sys(clk_sys), .reset_n(reset_n),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .conversion_done(conv),
        .alarm_cond(cond), .range_select(rsel),
        .onchip_reference_off(refoff), .frame_ctl(fctl),
        .frame_extra(fx), .irq(irq));

    // ===========================================================
    // Compare tasks
    task automatic chk_word(input logic [31:0] g, input logic [31:0] e);
        cmp_count++;
        if (g !== e)
        begin
            err_count++;
            $display("unexpected %0t word %h want %h", $time, g, e);
        end
    endtask

    task automatic chk_resp(input logic [1:0] g, input logic [1:0] e);
        cmp_count++;
        if (g !== e)
        begin
            err_count++;
            $display("unexpected %0t resp %h want %h", $time, g, e);
        end
    endtask

    // Read with expected data and response
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e,
                          input logic [1:0] er);
        logic [31:0] d;
        u_host.rd(a, d, r);
        chk_word(d, e);
        chk_resp(r, er);
    endtask

    // One comparator sample
    task automatic sample(input logic [3:0] c);
        @(posedge clk_sys);
        conv <= 1'b1;
        cond <= c;
        @(posedge clk_sys);
        conv <= 1'b0;
    endtask

    // ===========================================================
    // Scenarios
    task automatic t_reset();
        rd_chk(`RRAS_OFF_RANGE, 32'h0, `RRAS_RESP_OKAY);
        rd_chk(`RRAS_OFF_ALARM, 32'h0, `RRAS_RESP_OKAY);
        chk_word({31'h0, irq}, 32'h0);
    endtask

    task automatic t_range();
        logic [31:0] d;
        exp_rng = 4'h0;
        for (int i = 0; i < 16; i++)
        begin
            d = 32'hffff_ffb0 | i | ((i & 1) << 6);
            if (i <= 4 || (i >= 8 && i <= 11))
                exp_rng = i[3:0];
            u_host.wr(`RRAS_OFF_RANGE, d, r);
            chk_resp(r, `RRAS_RESP_OKAY);
            rd_chk(`RRAS_OFF_RANGE, {25'h0, d[0], 2'h0, exp_rng},
                   `RRAS_RESP_OKAY);
            chk_word({27'h0, refoff, rsel}, {27'h0, d[0], exp_rng});
        end
    endtask

    task automatic t_alarm();
        u_host.wr(`RRAS_OFF_IRQMSK, 32'hf, r);
        chk_word({31'h0, irq}, 32'h0);
        sample(4'b1010);
        rd_chk(`RRAS_OFF_ALARM, 32'h88a1, `RRAS_RESP_OKAY);
        chk_word({31'h0, irq}, 32'h1);
        rd_chk(`RRAS_OFF_IRQST, 32'ha, `RRAS_RESP_OKAY);
        u_host.wr(`RRAS_OFF_OUTCTL, 32'hc00, r);
        chk_word({28'h0, fx}, 32'h2);
        u_host.wr(`RRAS_OFF_OUTCTL, 32'h100, r);
        chk_word({25'h0, fctl, fx}, {25'h0, 3'b100, exp_rng});
        u_host.wr(`RRAS_OFF_IRQMSK, 32'h0, r);
        chk_word({31'h0, irq}, 32'h0);
        u_host.wr(`RRAS_OFF_IRQST, 32'ha, r);
        rd_chk(`RRAS_OFF_IRQST, 32'h0, `RRAS_RESP_OKAY);
        sample(4'b0000);
        rd_chk(`RRAS_OFF_ALARM, 32'h00a1, `RRAS_RESP_OKAY);
        rd_chk(`RRAS_OFF_ALARM, 32'h0, `RRAS_RESP_OKAY);
        sample(4'b0101);
        u_host.wr(`RRAS_OFF_ALARM, 32'hffff_ffff, r);
        chk_resp(r, `RRAS_RESP_OKAY);
        rd_chk(`RRAS_OFF_ALARM, 32'h4451, `RRAS_RESP_OKAY);
    endtask

    task automatic t_unmapped();
        u_host.wr(8'h08, 32'h1, r);
        chk_resp(r, `RRAS_RESP_SLVERR);
        rd_chk(8'h08, 32'h0, `RRAS_RESP_SLVERR);
        rd_chk(8'h24, 32'h0, `RRAS_RESP_SLVERR);
    endtask

    // ===========================================================
    // Verdict
    task automatic give_verdict();
        $display("compares %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // Main sequence
    initial
    begin
        repeat (12) @(posedge clk_sys);
        reset_n <= 1'b1;
        @(posedge clk_sys);
        t_reset();
        t_range();
        t_alarm();
        t_unmapped();
        give_verdict();
    end
endmodule

`default_nettype wire

// ==== tb/rras_host.sv ====
// Purpose: Host controller model speaking AXI4-Lite to the register block.
// Assumes: Ready and valid sampled at rising edges of clk_sys.
// Notes:   One write and one read at a time; waits without a cycle bound.
`timescale 1ns/1ps
`default_nettype none

module rras_host
(
    input  wire logic        clk_sys,
    output logic [7:0]       awaddr,
    output logic             awvalid,
    input  wire logic        awready,
    output logic [31:0]      wdata,
    output logic [3:0]       wstrb,
    output logic             wvalid,
    input  wire logic        wready,
    input  wire logic [1:0]  bresp,
    input  wire logic        bvalid,
    output logic             bready,
    output logic [7:0]       araddr,
    output logic             arvalid,
    input  wire logic        arready,
    input  wire logic [31:0] rdata,
    input  wire logic [1:0]  rresp,
    input  wire logic        rvalid,
    output logic             rready
);
    // ===========================================================
    // Idle levels from time zero
    initial
    begin
        {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
        {araddr, arvalid, rready} = '0;
    end

    // Write: address and data together, each dropped when taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      output logic [1:0] r);
        logic aw_ok, w_ok, b_ok;
        {aw_ok, w_ok, b_ok} = 3'b000;
        @(posedge clk_sys); // One edge between back-to-back transfers
        awaddr  <= a;
        wdata   <= d;
        wstrb   <= 4'hf;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        while (!b_ok)
        begin
            @(posedge clk_sys);
            if (!aw_ok && awready)
            begin
                aw_ok = 1'b1;
                awvalid <= 1'b0;
            end
            if (!w_ok && wready)
            begin
                w_ok = 1'b1;
                wvalid <= 1'b0;
            end
            if (bvalid)
            begin
                b_ok = 1'b1;
                r = bresp;
                bready <= 1'b0;
            end
        end
    endtask

    // Read: address held until taken, data taken with rvalid
    task automatic rd(input logic [7:0] a, output logic [31:0] d,
                      output logic [1:0] r);
        logic ar_ok, r_ok;
        {ar_ok, r_ok} = 2'b00;
        @(posedge clk_sys); // One edge between back-to-back transfers
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        while (!r_ok)
        begin
            @(posedge clk_sys);
            if (!ar_ok && arready)
            begin
                ar_ok = 1'b1;
                arvalid <= 1'b0;
            end
            if (rvalid)
            begin
                r_ok = 1'b1;
                d = rdata;
                r = rresp;
                rready <= 1'b0;
            end
        end
    endtask
endmodule

`default_nettype wire
